// ### design/bcr_pkg.sv
// Shared constants and types of the BCD calendar clock with alarm and wakeup timer.
// Assumes a single system clock domain; the oscillator arrives as an unsynchronised pin level.
package bcr_pkg;

  localparam int unsigned OSC_FREQ_HZ   = 32768;
  localparam int unsigned PRESC_W       = 15;
  localparam int unsigned WAKE_RELOAD_W = 16;
  localparam int unsigned WAKE_CNT_W    = WAKE_RELOAD_W + 1;

  localparam logic [7:0] RST_SEC   = 8'h00;
  localparam logic [7:0] RST_MIN   = 8'h00;
  localparam logic [7:0] RST_HOUR  = 8'h00;
  localparam logic [7:0] RST_DATE  = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h21;
  localparam logic [7:0] RST_YEAR  = 8'h00;

  localparam int unsigned HOUR_PM_BIT = 6;
  localparam int unsigned WDAY_LSB    = 5;
  localparam int unsigned WDAY_MSB    = 7;
  localparam int unsigned MONTH_MSB   = 4;

  localparam logic [2:0] WSEL_DIV16   = 3'h0;
  localparam logic [2:0] WSEL_DIV8    = 3'h1;
  localparam logic [2:0] WSEL_DIV4    = 3'h2;
  localparam logic [2:0] WSEL_DIV2    = 3'h3;
  localparam logic [2:0] WSEL_1HZ     = 3'h4;
  localparam logic [2:0] WSEL_1HZ_EXT = 3'h6;

  localparam int unsigned MSK_SEC   = 0;
  localparam int unsigned MSK_MIN   = 1;
  localparam int unsigned MSK_HOUR  = 2;
  localparam int unsigned MSK_DAY   = 3;
  localparam int unsigned MSK_MONTH = 4;

  // Six BCD bytes; hour bit 6 is the PM flag, month byte bits 7:5 hold the weekday.
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] wday_month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } bcr_time_s;

  typedef struct packed {
    logic       enable;
    logic [4:0] mask;
    logic       use_wday;
    bcr_time_s  match;
  } bcr_alarm_s;

  typedef struct packed {
    logic       alarm;
    logic       wakeup;
    logic       tamper;
  } bcr_flags_s;

endpackage

// ### design/bcr_rtc.sv
// BCD calendar clock with calendar alarm, periodic wakeup timer and tamper event.
// Assumes one system clock mclk; the low-speed oscillator and tamper pins are asynchronous levels.
// Overview of operation
// - Calendar time is kept in BCD in six byte-wide fields.
// - Hours count in 12-hour or 24-hour form, selected by an input, always BCD.
// - Date rolls after the month's true last day, leap years included.
// - Alarm and periodic wakeup events each raise a halt-exit request.
// - Oscillator divided by two gives 61 us steps, 61 us to 4 s.
// - One-second wakeup steps with extended count reach about 36 hours.
// - Alarm matches unmasked calendar fields, repeating every second up to yearly.
// - Alarm, wakeup and tamper share one interrupt that exits halt and wait modes.
`timescale 1ns/1ps
`default_nettype none

module bcr_rtc
#(
  parameter int unsigned PRESC_DIV = bcr_pkg::OSC_FREQ_HZ
)
(
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire logic                                  low_speed_external_osc,
  input  wire logic                                  tamper_pin,
  input  wire logic                                  hour_12h,
  input  wire logic                                  time_load,
  input  wire bcr_pkg::bcr_time_s                    time_in,
  input  wire bcr_pkg::bcr_alarm_s                   alarm_cfg,
  input  wire logic                                  wake_en,
  input  wire logic [2:0]                            wake_sel,
  input  wire logic [bcr_pkg::WAKE_RELOAD_W-1:0]     wake_reload,
  input  wire logic                                  tamper_en,
  input  wire bcr_pkg::bcr_flags_s                   flag_clr,
  output var  bcr_pkg::bcr_time_s                    time_r,
  output var  bcr_pkg::bcr_flags_s                   flags_r,
  output var  logic                                  sec_pulse_r,
  output var  logic                                  irq_r
);
  import bcr_pkg::*;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] last_day(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 5'h02)
    begin
      last_day = leap ? 8'h29 : 8'h28;
    end
    else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
    begin
      last_day = 8'h30;
    end
    else
    begin
      last_day = 8'h31;
    end
  endfunction

  logic [1:0]               osc_sync_r;
  logic [1:0]               tmp_sync_r;
  logic                     osc_prev_r;
  logic                     tmp_prev_r;
  logic [PRESC_W-1:0]       presc_r;
  logic [PRESC_W-1:0]       presc_nxt;
  logic [3:0]               wdiv_r;
  logic [3:0]               wdiv_nxt;
  logic [WAKE_CNT_W-1:0]    wcnt_r;
  logic [WAKE_CNT_W-1:0]    wcnt_nxt;
  logic                     sec_upd_r;
  logic                     sec_upd_nxt;
  bcr_time_s                time_nxt;
  bcr_flags_s               flags_nxt;
  logic                     irq_nxt;
  logic                     osc_tick;
  logic                     sec_tick;
  logic                     wake_tick;
  logic                     alarm_hit;
  logic [WAKE_CNT_W-1:0]    wake_load;

  // Oscillator and tamper pins pass two flops before any edge detection.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      osc_sync_r <= 2'h0;
      tmp_sync_r <= 2'h0;
      osc_prev_r <= 1'b0;
      tmp_prev_r <= 1'b0;
    end
    else
    begin
      osc_sync_r <= {osc_sync_r[0], low_speed_external_osc};
      tmp_sync_r <= {tmp_sync_r[0], tamper_pin};
      osc_prev_r <= osc_sync_r[1];
      tmp_prev_r <= tmp_sync_r[1];
    end
  end

  always_comb
  begin
    logic [7:0] h;
    logic       pm;
    logic       c_min;
    logic       c_hour;
    logic       c_day;
    logic       c_mon;
    logic       c_year;
    logic [4:0] mon;
    logic [2:0] wd;
    h      = {2'h0, time_r.hour[5:0]};
    pm     = time_r.hour[HOUR_PM_BIT];
    c_min  = 1'b0;
    c_hour = 1'b0;
    c_day  = 1'b0;
    c_mon  = 1'b0;
    c_year = 1'b0;
    mon    = time_r.wday_month[MONTH_MSB:0];
    wd     = time_r.wday_month[WDAY_MSB:WDAY_LSB];

    osc_tick = osc_sync_r[1] & ~osc_prev_r;
    presc_nxt = presc_r;
    sec_tick  = 1'b0;
    if (time_load)
    begin
      presc_nxt = '0;
    end
    else if (osc_tick)
    begin
      if (presc_r == PRESC_W'(PRESC_DIV - 1))
      begin
        presc_nxt = '0;
        sec_tick  = 1'b1;
      end
      else
      begin
        presc_nxt = presc_r + PRESC_W'(1);
      end
    end

    time_nxt = time_r;
    if (time_load)
    begin
      time_nxt = time_in;
    end
    else if (sec_tick)
    begin
      if (time_r.sec == 8'h59)
      begin
        time_nxt.sec = 8'h00;
        c_min        = 1'b1;
      end
      else
      begin
        time_nxt.sec = bcd_inc(time_r.sec);
      end
      if (c_min)
      begin
        if (time_r.min == 8'h59)
        begin
          time_nxt.min = 8'h00;
          c_hour       = 1'b1;
        end
        else
        begin
          time_nxt.min = bcd_inc(time_r.min);
        end
      end
      if (c_hour)
      begin
        if (hour_12h)
        begin
          if (h == 8'h12)
          begin
            h = 8'h01;
          end
          else if (h == 8'h11)
          begin
            h     = 8'h12;
            c_day = pm;
            pm    = ~pm;
          end
          else
          begin
            h = bcd_inc(h);
          end
        end
        else if (h == 8'h23)
        begin
          h     = 8'h00;
          c_day = 1'b1;
          pm    = 1'b0;
        end
        else
        begin
          h = bcd_inc(h);
        end
        time_nxt.hour = {1'b0, pm, h[5:0]};
      end
      if (c_day)
      begin
        wd = (wd == 3'h7) ? 3'h1 : wd + 3'h1;
        if (time_r.date == last_day(mon, time_r.year))
        begin
          time_nxt.date = 8'h01;
          c_mon         = 1'b1;
        end
        else
        begin
          time_nxt.date = bcd_inc(time_r.date);
        end
      end
      if (c_mon)
      begin
        if (mon == 5'h12)
        begin
          mon    = 5'h01;
          c_year = 1'b1;
        end
        else
        begin
          mon = 5'(bcd_inc({3'h0, mon}));
        end
      end
      time_nxt.wday_month = {wd, mon};
      if (c_year)
      begin
        time_nxt.year = (time_r.year == 8'h99) ? 8'h00 : bcd_inc(time_r.year);
      end
    end
    sec_upd_nxt = sec_tick;
  end

  // Matching is done on the freshly updated time, so each second is judged exactly once.
  always_comb
  begin
    alarm_hit = alarm_cfg.enable & sec_upd_r;
    if (!alarm_cfg.mask[MSK_SEC] && time_r.sec != alarm_cfg.match.sec)
    begin
      alarm_hit = 1'b0;
    end
    if (!alarm_cfg.mask[MSK_MIN] && time_r.min != alarm_cfg.match.min)
    begin
      alarm_hit = 1'b0;
    end
    if (!alarm_cfg.mask[MSK_HOUR] && time_r.hour[6:0] != alarm_cfg.match.hour[6:0])
    begin
      alarm_hit = 1'b0;
    end
    if (!alarm_cfg.mask[MSK_DAY])
    begin
      if (alarm_cfg.use_wday)
      begin
        if (time_r.wday_month[WDAY_MSB:WDAY_LSB] != alarm_cfg.match.wday_month[WDAY_MSB:WDAY_LSB])
        begin
          alarm_hit = 1'b0;
        end
      end
      else if (time_r.date != alarm_cfg.match.date)
      begin
        alarm_hit = 1'b0;
      end
    end
    if (!alarm_cfg.mask[MSK_MONTH]
        && time_r.wday_month[MONTH_MSB:0] != alarm_cfg.match.wday_month[MONTH_MSB:0])
    begin
      alarm_hit = 1'b0;
    end
  end

  // The wakeup counter reloads on expiry; a reload of N gives a period of N+1 steps.
  always_comb
  begin
    wdiv_nxt  = osc_tick ? wdiv_r + 4'h1 : wdiv_r;
    wake_load = {(wake_sel == WSEL_1HZ_EXT || wake_sel == 3'h7), wake_reload};
    if (wake_sel == WSEL_DIV16)
    begin
      wake_tick = osc_tick & (wdiv_r == 4'hf);
    end
    else if (wake_sel == WSEL_DIV8)
    begin
      wake_tick = osc_tick & (wdiv_r[2:0] == 3'h7);
    end
    else if (wake_sel == WSEL_DIV4)
    begin
      wake_tick = osc_tick & (wdiv_r[1:0] == 2'h3);
    end
    else if (wake_sel == WSEL_DIV2)
    begin
      wake_tick = osc_tick & wdiv_r[0];
    end
    else
    begin
      wake_tick = sec_tick;
    end
    wcnt_nxt = wcnt_r;
    if (!wake_en)
    begin
      wcnt_nxt = wake_load;
    end
    else if (wake_tick)
    begin
      wcnt_nxt = (wcnt_r == '0) ? wake_load : wcnt_r - WAKE_CNT_W'(1);
    end

    // A new event in the clearing cycle keeps its flag set.
    flags_nxt.alarm  = alarm_hit | (flags_r.alarm & ~flag_clr.alarm);
    flags_nxt.wakeup = (wake_en & wake_tick & (wcnt_r == '0))
                       | (flags_r.wakeup & ~flag_clr.wakeup);
    flags_nxt.tamper = (tamper_en & tmp_sync_r[1] & ~tmp_prev_r)
                       | (flags_r.tamper & ~flag_clr.tamper);
    irq_nxt = flags_nxt.alarm | flags_nxt.wakeup | flags_nxt.tamper;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      presc_r     <= '0;
      wdiv_r      <= 4'h0;
      wcnt_r      <= '0;
      sec_upd_r   <= 1'b0;
      sec_pulse_r <= 1'b0;
      time_r      <= '{year: RST_YEAR, wday_month: RST_MONTH, date: RST_DATE,
                       hour: RST_HOUR, min: RST_MIN, sec: RST_SEC};
      flags_r     <= '0;
      irq_r       <= 1'b0;
    end
    else
    begin
      presc_r     <= presc_nxt;
      wdiv_r      <= wdiv_nxt;
      wcnt_r      <= wcnt_nxt;
      sec_upd_r   <= sec_upd_nxt;
      sec_pulse_r <= sec_upd_nxt;
      time_r      <= time_nxt;
      flags_r     <= flags_nxt;
      irq_r       <= irq_nxt;
    end
  end

endmodule

`default_nettype wire

// ### test/bcr_rtc_chk.sv
// Port checker of the calendar clock with alarm, wakeup and tamper.
// Assumes binding to bcr_rtc with the same PRESC_DIV.
`timescale 1ns/1ps
`default_nettype none
module bcr_rtc_chk
#(
  parameter int unsigned PRESC_DIV = 4
)
(
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               tamper_pin,
  input wire logic               tamper_en,
  input wire logic               time_load,
  input wire logic               wake_en,
  input wire bcr_pkg::bcr_flags_s flag_clr,
  input wire bcr_pkg::bcr_time_s  time_r,
  input wire bcr_pkg::bcr_flags_s flags_r,
  input wire logic               sec_pulse_r,
  input wire logic               irq_r
);
  import bcr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Ticks are at least two cycles apart, so a second can never be shorter.
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  always_comb
  begin
    gap_nxt = gap_r;
    if (sec_pulse_r)
      gap_nxt = 16'h0000;
    else if (gap_r != 16'hffff)
      gap_nxt = gap_r + 16'h0001;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_nxt;
  end
  irq_or_a: assert property (irq_r == |flags_r)
    else $error("irq differs from flags");
  pulse_one_a: assert property (sec_pulse_r |=> !sec_pulse_r)
    else $error("second pulse too long");
  sec_gap_a: assert property (sec_pulse_r |-> gap_r >= 2 * PRESC_DIV - 1)
    else $error("seconds too close");
  time_hold_a: assert property ($changed(time_r) |-> sec_pulse_r || $past(time_load) || $past(rst))
    else $error("time moved without a second");
  sec_bcd_a: assert property (sec_pulse_r |-> time_r.sec[3:0] <= 4'h9 && time_r.min[3:0] <= 4'h9)
    else $error("time not BCD");
  alarm_src_a: assert property ($rose(flags_r.alarm) |-> $past(sec_pulse_r))
    else $error("alarm without second");
  alarm_keep_a: assert property (flags_r.alarm && !flag_clr.alarm |=> flags_r.alarm)
    else $error("alarm flag lost");
  tamper_set_a: assert property (tamper_en && $rose(tamper_pin) |-> ##[1:5] flags_r.tamper)
    else $error("tamper flag late");
  wake_src_a: assert property ($rose(flags_r.wakeup) |-> $past(wake_en))
    else $error("wakeup while disabled");
  reset_val_a: assert property (disable iff (1'b0) rst |=> time_r.date == RST_DATE && flags_r == 3'h0)
    else $error("reset value wrong");
endmodule
`default_nettype wire

// ### test/bcr_rtc_tb.sv
// Self-checking bench of the calendar clock with alarm, wakeup and tamper.
// Assumes bcr_rtc with a shortened second prescaler and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module bcr_rtc_tb;
  import bcr_pkg::*;
  logic       mclk, rst, osc, tamper_pin, hour_12h, time_load, wake_en, tamper_en;
  logic       sec_pulse_r, irq_r;
  logic [2:0] div, wake_sel;
  logic [15:0] wake_reload;
  bcr_time_s  time_in, time_r;
  bcr_alarm_s alarm_cfg;
  bcr_flags_s flag_clr, flags_r;
  int         mismatches, tests_run;
  bcr_rtc #(.PRESC_DIV(4)) DUT (.mclk(mclk), .rst(rst), .low_speed_external_osc(osc),
    .tamper_pin(tamper_pin), .hour_12h(hour_12h), .time_load(time_load), .time_in(time_in),
    .alarm_cfg(alarm_cfg), .wake_en(wake_en), .wake_sel(wake_sel), .wake_reload(wake_reload),
    .tamper_en(tamper_en), .flag_clr(flag_clr), .time_r(time_r), .flags_r(flags_r),
    .sec_pulse_r(sec_pulse_r), .irq_r(irq_r));
  // The oscillator ticks every 8 cycles, so all periods are exact.
  always @(posedge mclk)
  begin
    div <= div + 3'h1;
    osc <= div[2];
  end
  task automatic chkv(input string n, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chkv(n, {47'h0, e}, {47'h0, g});
  endtask
  task automatic step(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic load(input logic [47:0] t);
    @(posedge mclk);
    time_in <= t;
    time_load <= 1'b1;
    @(posedge mclk);
    time_load <= 1'b0;
    #1;
  endtask
  task automatic wait_sec();
    for (int k = 0; k < 400 && sec_pulse_r !== 1'b1; k++)
      step(1);
    chk1("sec_pulse", 1'b1, sec_pulse_r);
  endtask
  task automatic t_calendar();
    logic [47:0] ti [7];
    logic [47:0] te [7];
    ti = '{48'h24222823_5959, 48'h23222823_5959, 48'h00643023_5959, 48'h99f23123_5959,
           48'h00210111_5959, 48'h00210151_5959, 48'h00210152_5959};
    te = '{48'h24422900_0000, 48'h23430100_0000, 48'h00850100_0000, 48'h00210100_0000,
           48'h00210152_0000, 48'h00410212_0000, 48'h00210141_0000};
    for (int i = 0; i < 7; i++)
    begin
      hour_12h <= (i > 3);
      load(ti[i]);
      wait_sec();
      chkv("calendar", te[i], time_r);
    end
  endtask
  task automatic t_alarm();
    bcr_alarm_s  cfg [2];
    logic [47:0] tm [2];
    // The second pass compares the weekday while the date differs, so only the weekday path can match.
    cfg = '{'{enable: 1'b1, mask: 5'h1e, use_wday: 1'b0, match: 48'h00210100_0005},
            '{enable: 1'b1, mask: 5'h16, use_wday: 1'b1, match: 48'h00e00000_0007}};
    tm = '{48'h00210100_0004, 48'h00e10100_0006};
    hour_12h <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      alarm_cfg <= cfg[i];
      load(tm[i]);
      wait_sec();
      step(1);
      chk1("alarm", 1'b1, flags_r.alarm);
      chk1("irq", 1'b1, irq_r);
      alarm_cfg.enable <= 1'b0;
      flag_clr.alarm <= 1'b1;
      @(posedge mclk);
      flag_clr.alarm <= 1'b0;
      step(1);
      chk1("irq_clr", 1'b0, irq_r);
    end
  endtask
  task automatic t_tamper();
    tamper_en <= 1'b1;
    @(posedge mclk);
    tamper_pin <= 1'b1;
    step(6);
    chk1("tamper_irq", 1'b1, irq_r);
  endtask
  task automatic t_wake();
    int n;
    wake_reload <= 16'h0001;
    wake_en <= 1'b1;
    for (int s = 0; s < 5; s++)
    begin
      wake_sel <= 3'(s);
      // The first period after a step change has an unknown phase, so the second is timed.
      repeat (2)
      begin
        flag_clr.wakeup <= 1'b1;
        @(posedge mclk);
        flag_clr.wakeup <= 1'b0;
        step(0);
        for (n = 1; n < 600 && flags_r.wakeup !== 1'b1; n++)
          step(1);
      end
      chkv("wake_period", 48'((s < 4) ? (256 >> s) : 64), 48'(n));
    end
    // With the extended count a zero reload must last far longer than a few seconds.
    wake_en <= 1'b0;
    wake_reload <= 16'h0000;
    wake_sel <= WSEL_1HZ_EXT;
    flag_clr.wakeup <= 1'b1;
    @(posedge mclk);
    flag_clr.wakeup <= 1'b0;
    wake_en <= 1'b1;
    step(160);
    chk1("wake_ext", 1'b0, flags_r.wakeup);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    #2000000;
    mismatches++;
    finish_test();
  end
  initial
  begin
    {rst, div, osc, tamper_pin, hour_12h, time_load, wake_en, tamper_en} = 10'h200;
    {wake_sel, wake_reload, time_in, alarm_cfg, flag_clr} = '0;
    mismatches = 0;
    tests_run = 0;
    step(3);
    rst <= 1'b0;
    step(1);
    chkv("reset", 48'h00210100_0000, time_r);
    t_calendar();
    t_alarm();
    t_tamper();
    t_wake();
    finish_test();
  end
endmodule
bind bcr_rtc bcr_rtc_chk #(.PRESC_DIV(PRESC_DIV)) u_chk (.mclk(mclk), .rst(rst), .tamper_pin(tamper_pin),
  .tamper_en(tamper_en), .time_load(time_load), .wake_en(wake_en), .flag_clr(flag_clr), .time_r(time_r),
  .flags_r(flags_r), .sec_pulse_r(sec_pulse_r), .irq_r(irq_r));
`default_nettype wire
